// ### logic/fze_exceptions.sv
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
module fze_exceptions
   import fze_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   input  wire fze_req_s    req,
   input  wire logic        wait_check,
   output fze_wb_s          wb,
   output logic             handler_req,
   output logic [15:0]      control_word,
   output logic [15:0]      status_word
);

   function automatic logic signed [19:0] fmt_emax(input fze_fmt_e f);
      case (f)
         FZE_FMT_SINGLE: fmt_emax = 20'(EMAX_SINGLE);
         FZE_FMT_DOUBLE: fmt_emax = 20'(EMAX_DOUBLE);
         default:        fmt_emax = 20'(EMAX_EXT);
      endcase
   endfunction

   function automatic logic signed [19:0] fmt_emin(input fze_fmt_e f);
      case (f)
         FZE_FMT_SINGLE: fmt_emin = 20'(EMIN_SINGLE);
         FZE_FMT_DOUBLE: fmt_emin = 20'(EMIN_DOUBLE);
         default:        fmt_emin = 20'(EMIN_EXT);
      endcase
   endfunction

   // Significand holding as many leading ones as the format keeps
   function automatic logic [63:0] max_sig(input int bits);
      logic [63:0] m;
      m = '0;
      for (int i = 0; i < SIG_EXT; i++) begin
         if (i >= SIG_EXT - bits) begin
            m[i] = 1'b1;
         end
      end
      max_sig = m;
   endfunction

   function automatic logic [79:0] pack(input logic s,
                                        input logic signed [19:0] e,
                                        input logic [63:0] m);
      logic signed [19:0] be;
      be = e + 20'(EXP_BIAS);
      pack = {s, be[14:0], m};
   endfunction

   function automatic logic [79:0] infinity(input logic s);
      infinity = {s, EXP_ALL_ONES, 1'b1, 63'h0};
   endfunction

   function automatic logic [79:0] zero(input logic s);
      zero = {s, 79'h0};
   endfunction

   fze_rc_e            rc;
   logic [1:0]         pc;
   logic               mask_zd;
   logic               mask_ov;
   logic               mask_un;
   logic               setup;
   logic               acc_wr;
   logic               is_div;
   logic               is_rev;
   logic               dvd_sign;
   logic               dvd_zero;
   logic               dvd_finite;
   logic               dvs_sign;
   logic               dvs_zero;
   logic               dz_div;
   logic               dz_log;
   logic               dz_ext;
   logic               dz;
   logic               range_chk;
   fze_fmt_e           dfmt;
   logic signed [19:0] rexp;
   logic signed [19:0] emax;
   logic signed [19:0] emin;
   logic               ovf;
   logic               unf;
   int                 sig_bits;
   logic signed [19:0] shifted_exp;
   logic [63:0]        denorm_sig;
   logic signed [19:0] shift_amt;
   logic               unmasked;
   fze_wb_s            next_wb;

   assign rc       = fze_rc_e'(control_word[BIT_RC_LO +: 2]);
   assign pc       = control_word[BIT_PREC_LO +: 2];
   assign mask_zd  = control_word[BIT_ZERO_DIVIDE];
   assign mask_ov  = control_word[BIT_OVERFLOW];
   assign mask_un  = control_word[BIT_UNDERFLOW];
   assign setup    = psel && !penable;
   assign acc_wr   = psel && penable && pready && pwrite;

   // Reverse forms divide the top by the other operand
   always_comb begin
      is_div = req.op inside {FZE_OP_DIVIDE, FZE_OP_DIVIDE_POP,
                              FZE_OP_REVERSE_DIVIDE,
                              FZE_OP_INTEGER_DIVIDE,
                              FZE_OP_INTEGER_REVERSE_DIVIDE};  // [RULE2]
      is_rev = req.op inside {FZE_OP_REVERSE_DIVIDE,
                              FZE_OP_INTEGER_REVERSE_DIVIDE};
      dvd_sign   = is_rev ? req.a_sign   : req.b_sign;
      dvd_zero   = is_rev ? req.a_zero   : req.b_zero;
      dvd_finite = is_rev ? req.a_finite : req.b_finite;
      dvs_sign   = is_rev ? req.b_sign   : req.a_sign;
      dvs_zero   = is_rev ? req.b_zero   : req.a_zero;
   end

   always_comb begin
      dz_div = is_div && dvd_finite && !dvd_zero && dvs_zero;   // [RULE1]
      dz_log = (req.op == FZE_OP_LOG_PRODUCT) && req.a_zero
               && req.b_finite && !req.b_zero;                  // [RULE2]
      dz_ext = (req.op == FZE_OP_EXPONENT_EXTRACT) && req.a_zero; // [RULE2]
      dz     = req.valid && (dz_div || dz_log || dz_ext);
   end

   // Integer and decimal stores report range trouble as invalid elsewhere
   always_comb begin
      range_chk = req.valid && req.res_number && !dz
                  && !(req.op inside {FZE_OP_INTEGER_STORE,
                                      FZE_OP_DECIMAL_STORE}); // [RULE8] [RULE16]
      dfmt = req.dest_mem ? req.fmt : FZE_FMT_EXTENDED;
      rexp = 20'(signed'(req.res_exp));
      emax = fmt_emax(dfmt);
      emin = fmt_emin(dfmt);
      ovf  = range_chk && (rexp > emax);                    // [RULE7]
      unf  = range_chk && (rexp < emin);                    // [RULE15]
   end

   always_comb begin
      if (req.dest_mem) begin
         case (req.fmt)
            FZE_FMT_SINGLE: sig_bits = SIG_SINGLE;
            FZE_FMT_DOUBLE: sig_bits = SIG_DOUBLE;
            default:        sig_bits = SIG_EXT;
         endcase
      end else if (!req.uses_precision) begin
         sig_bits = SIG_EXT;
      end else begin
         case (pc)
            2'b00:   sig_bits = SIG_SINGLE;
            2'b10:   sig_bits = SIG_DOUBLE;
            default: sig_bits = SIG_EXT;
         endcase
      end
   end

   // Denormal: the significand slides right until the exponent is emin
   always_comb begin
      shift_amt  = emin - rexp;
      denorm_sig = (shift_amt >= 20'sd64) ? 64'h0
                   : (req.res_sig >> shift_amt[5:0]);
      shifted_exp = ovf ? rexp - 20'(REBIAS) : rexp + 20'(REBIAS);
   end

   assign unmasked = (dz && !mask_zd) || (ovf && !mask_ov)
                     || (unf && !mask_un);

   always_comb begin
      next_wb = '0;
      next_wb.dest_mem           = req.dest_mem;
      next_wb.raised_zero_divide = dz;
      next_wb.raised_overflow    = ovf;
      next_wb.raised_underflow   = unf;
      if (dz) begin
         if (mask_zd) begin
            if (dz_ext) begin
               next_wb.write_second = 1'b1;
               next_wb.second_value = infinity(1'b1);              // [RULE5]
               next_wb.write_top    = 1'b1;
               next_wb.top_value    = zero(req.a_sign);             // [RULE5]
            end else if (dz_log) begin
               next_wb.write_top = 1'b1;
               next_wb.top_value = infinity(!req.b_sign);           // [RULE4]
            end else begin
               next_wb.write_top = 1'b1;
               next_wb.top_value = infinity(dvd_sign ^ dvs_sign);   // [RULE3]
            end
         end
         // Unmasked: no write, stack and operands stay as they were [RULE6]
      end else if (ovf) begin
         if (mask_ov) begin
            next_wb.write_top = 1'b1;
            if (rc == FZE_RC_NEAREST || (rc == FZE_RC_DOWN && req.res_sign)
                || (rc == FZE_RC_UP && !req.res_sign)) begin
               next_wb.top_value = infinity(req.res_sign);           // [RULE10]
            end else begin
               next_wb.top_value = pack(req.res_sign, emax,
                                        max_sig(sig_bits));          // [RULE10]
            end
         end else if (req.dest_mem) begin
            next_wb.update_round_up = 1'b1;                          // [RULE11]
         end else begin
            next_wb.write_top       = 1'b1;
            next_wb.update_round_up = 1'b1;
            next_wb.round_up        = req.rounded_up;                // [RULE13]
            if (req.op == FZE_OP_SCALE && shifted_exp > emax) begin
               next_wb.top_value = infinity(req.res_sign);           // [RULE14]
            end else begin
               next_wb.top_value = pack(req.res_sign, shifted_exp,
                                        req.res_sig);                // [RULE12]
            end
         end
      end else if (unf) begin
         if (mask_un) begin
            next_wb.write_top = 1'b1;
            next_wb.top_value = {req.res_sign,
                                 (dfmt == FZE_FMT_EXTENDED) ? 15'h0000
                                 : 15'(emin + 20'(EXP_BIAS)),
                                 denorm_sig};                        // [RULE22]
         end else if (req.dest_mem) begin
            next_wb.update_round_up = 1'b1;                          // [RULE18]
         end else begin
            next_wb.write_top       = 1'b1;
            next_wb.update_round_up = 1'b1;
            next_wb.round_up        = req.rounded_up;                // [RULE19]
            if (req.op == FZE_OP_SCALE && shifted_exp < emin) begin
               next_wb.top_value = zero(req.res_sign);               // [RULE20]
            end else begin
               next_wb.top_value = pack(req.res_sign, shifted_exp,
                                        req.res_sig);                // [RULE19]
            end
         end
      end
   end

   // Result and its flags leave together, one cycle after the request
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wb <= '0;
      end else begin
         wb <= next_wb;                                              // [RULE13]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         control_word <= CONTROL_RESET;
      end else if (acc_wr && paddr == ADDR_CONTROL) begin
         control_word <= pwdata[15:0] & CONTROL_MASK;   // [RULE1] [RULE9] [RULE17]
      end
   end

   // Flags clear by writing one; a flag raised in the same cycle survives
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_word <= STATUS_RESET;
      end else begin
         logic [15:0] clr;
         logic [15:0] s;
         clr = (acc_wr && paddr == ADDR_STATUS) ? pwdata[15:0] : 16'h0000;
         s = status_word;
         s[BIT_ZERO_DIVIDE] = (s[BIT_ZERO_DIVIDE] && !clr[BIT_ZERO_DIVIDE])
                              || next_wb.raised_zero_divide;         // [RULE1]
         s[BIT_OVERFLOW]    = (s[BIT_OVERFLOW] && !clr[BIT_OVERFLOW])
                              || next_wb.raised_overflow;            // [RULE9]
         s[BIT_UNDERFLOW]   = (s[BIT_UNDERFLOW] && !clr[BIT_UNDERFLOW])
                              || next_wb.raised_underflow;  // [RULE17] [RULE23]
         s[BIT_SUMMARY]     = (s[BIT_SUMMARY] && !clr[BIT_SUMMARY])
                              || unmasked;                           // [RULE6]
         if (next_wb.update_round_up) begin
            s[BIT_ROUND_UP] = next_wb.round_up;                      // [RULE13]
         end else if (clr[BIT_ROUND_UP]) begin
            s[BIT_ROUND_UP] = 1'b0;
         end
         status_word <= s;
      end
   end

   // Handler waits for the next waiting instruction to look at the summary
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         handler_req <= 1'b0;
      end else begin
         handler_req <= wait_check && status_word[BIT_SUMMARY];      // [RULE21]
      end
   end

   // Zero-wait slave: answer registered during setup, ready in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         pready  <= 1'b1;
         pslverr <= !(paddr == ADDR_CONTROL || paddr == ADDR_STATUS);
         if (pwrite) begin
            prdata <= 32'h0000_0000;
         end else if (paddr == ADDR_CONTROL) begin
            prdata <= {16'h0000, control_word};
         end else if (paddr == ADDR_STATUS) begin
            prdata <= {16'h0000, status_word};
         end else begin
            prdata <= 32'h0000_0000;
         end
      end else begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end
   end

endmodule

// ### logic/fze_pkg.sv
// Operation
// [RULE1] Finite nonzero divided by zero raises zero-divide
// [RULE2] Divides, integer divides, log, extract report it
// [RULE3] Masked divide: infinity, sign is XOR of signs
// [RULE4] Masked log: infinity opposite non-zero operand sign
// [RULE5] Masked extract: second minus infinity, top signed zero
// [RULE6] Unmasked zero-divide: flag, handler, nothing modified
// [RULE7] Rounded result above format maximum is overflow
// [RULE8] Check registers and narrowing stores; never integer stores
// [RULE9] Overflow flag and mask at bit 3
// [RULE10] Masked overflow result follows rounding mode
// [RULE11] Unmasked memory overflow: flag, handler, nothing modified; the code still clears the round-up bit
// [RULE12] Unmasked register overflow: exponent minus 24576, store
// [RULE13] Round-up bit from rounding, then flag and handler
// [RULE14] Scale overflowing again stores signed infinity
// [RULE15] Rounded result below normal minimum is underflow
// [RULE16] Integer and decimal stores never signal underflow
// [RULE17] Underflow flag and mask at bit 4
// [RULE18] Unmasked memory underflow: flag, handler, no write
// [RULE19] Unmasked register underflow: exponent plus 24576, store
// [RULE20] Scale underflowing again stores signed zero
// [RULE21] Handler taken only when waiting instruction sees summary
// [RULE22] Masked underflow delivers denormal or signed zero
// [RULE23] Several exceptions at once set all flags together
package fze_pkg;

   localparam logic [31:0] ADDR_CONTROL = 32'h0000_0000;
   localparam logic [31:0] ADDR_STATUS  = 32'h0000_0004;

   localparam int          BIT_ZERO_DIVIDE = 2;
   localparam int          BIT_OVERFLOW    = 3;
   localparam int          BIT_UNDERFLOW   = 4;
   localparam int          BIT_SUMMARY     = 7;
   localparam int          BIT_PREC_LO     = 8;
   localparam int          BIT_ROUND_UP    = 9;
   localparam int          BIT_RC_LO       = 10;

   localparam logic [15:0] CONTROL_RESET = 16'h031C;
   localparam logic [15:0] CONTROL_MASK  = 16'h0F1C;
   localparam logic [15:0] STATUS_RESET  = 16'h0000;

   localparam int          EXP_BIAS     = 16383;
   localparam int          REBIAS       = 24576;
   localparam int          EMAX_EXT     = 16383;
   localparam int          EMIN_EXT     = -16382;
   localparam int          EMAX_DOUBLE  = 1023;
   localparam int          EMIN_DOUBLE  = -1022;
   localparam int          EMAX_SINGLE  = 127;
   localparam int          EMIN_SINGLE  = -126;
   localparam int          SIG_EXT      = 64;
   localparam int          SIG_DOUBLE   = 53;
   localparam int          SIG_SINGLE   = 24;
   localparam logic [14:0] EXP_ALL_ONES = 15'h7FFF;

   typedef enum logic [3:0] {
      FZE_OP_OTHER,
      FZE_OP_DIVIDE,
      FZE_OP_DIVIDE_POP,
      FZE_OP_REVERSE_DIVIDE,
      FZE_OP_INTEGER_DIVIDE,
      FZE_OP_INTEGER_REVERSE_DIVIDE,
      FZE_OP_LOG_PRODUCT,
      FZE_OP_EXPONENT_EXTRACT,
      FZE_OP_FLOAT_STORE,
      FZE_OP_FLOAT_STORE_POP,
      FZE_OP_INTEGER_STORE,
      FZE_OP_DECIMAL_STORE,
      FZE_OP_SCALE
   } fze_op_e;

   typedef enum logic [1:0] {
      FZE_FMT_EXTENDED,
      FZE_FMT_DOUBLE,
      FZE_FMT_SINGLE
   } fze_fmt_e;

   typedef enum logic [1:0] {
      FZE_RC_NEAREST,
      FZE_RC_DOWN,
      FZE_RC_UP,
      FZE_RC_CHOP
   } fze_rc_e;

   typedef struct packed {
      logic        valid;
      fze_op_e     op;
      logic        dest_mem;
      fze_fmt_e    fmt;
      logic        uses_precision;
      logic        a_sign;
      logic        a_zero;
      logic        a_finite;
      logic        b_sign;
      logic        b_zero;
      logic        b_finite;
      logic        res_number;
      logic        res_sign;
      logic [17:0] res_exp;
      logic [63:0] res_sig;
      logic        rounded_up;
   } fze_req_s;

   typedef struct packed {
      logic        write_top;
      logic [79:0] top_value;
      logic        write_second;
      logic [79:0] second_value;
      logic        dest_mem;
      logic        update_round_up;
      logic        round_up;
      logic        raised_zero_divide;
      logic        raised_overflow;
      logic        raised_underflow;
   } fze_wb_s;

endpackage

// ### sim/fze_exceptions_asserts.sv
`timescale 1ns/1ps
module fze_exceptions_asserts
   import fze_pkg::*;
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic [31:0] prdata,
   input wire logic        pslverr,
   input wire fze_req_s    req,
   input wire logic        wait_check,
   input wire fze_wb_s     wb,
   input wire logic        handler_req,
   input wire logic [15:0] control_word,
   input wire logic [15:0] status_word
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   logic               is_div;
   logic               is_rev;
   logic signed [17:0] rexp;
   // Reverse forms take the divisor from the other operand
   assign is_rev = req.op inside {FZE_OP_REVERSE_DIVIDE,
      FZE_OP_INTEGER_REVERSE_DIVIDE};
   assign is_div = req.op inside {FZE_OP_DIVIDE, FZE_OP_DIVIDE_POP,
      FZE_OP_REVERSE_DIVIDE, FZE_OP_INTEGER_DIVIDE,
      FZE_OP_INTEGER_REVERSE_DIVIDE};
   assign rexp = req.res_exp;

   sequence s_div_zero;
      req.valid && is_div && (is_rev
         ? (req.b_zero && !req.a_zero && req.a_finite)
         : (req.a_zero && !req.b_zero && req.b_finite));
   endsequence
   // Register results only: memory stores never get rebiased
   sequence s_reg_req;
      req.valid && req.op == FZE_OP_OTHER && !req.dest_mem && req.res_number;
   endsequence

   a_zdiv_masked: assert property (s_div_zero ##0 control_word[2]
      |=> wb.write_top && wb.raised_zero_divide && wb.top_value[79:64] ==
      {$past(req.a_sign) ^ $past(req.b_sign), EXP_ALL_ONES})
      else $error("masked divide by zero result wrong");
   a_zdiv_unmasked: assert property (s_div_zero ##0 !control_word[2]
      |=> !wb.write_top && !wb.write_second && status_word[2]
      && status_word[BIT_SUMMARY])
      else $error("unmasked divide by zero wrong");
   a_flags_follow: assert property (wb.raised_zero_divide
      || wb.raised_overflow || wb.raised_underflow |->
      ({wb.raised_underflow, wb.raised_overflow, wb.raised_zero_divide}
      & ~status_word[4:2]) == 3'b000)
      else $error("raised exception without sticky flag");
   a_int_quiet: assert property (req.valid && req.op inside
      {FZE_OP_INTEGER_STORE, FZE_OP_DECIMAL_STORE}
      |=> !wb.raised_overflow && !wb.raised_underflow)
      else $error("integer store raised range exception");
   a_handler_gate: assert property (wait_check
      && status_word[BIT_SUMMARY] |=> handler_req)
      else $error("pending exception not taken");
   a_mem_nowrite: assert property ($past(req.dest_mem) &&
      (wb.raised_overflow && !$past(control_word[3]) ||
      wb.raised_underflow && !$past(control_word[4]))
      |-> !wb.write_top && !wb.round_up)
      else $error("unmasked store range fault wrote");
   a_ovf_rebias: assert property (s_reg_req ##0 rexp > EMAX_EXT
      && rexp <= EMAX_EXT + REBIAS && !control_word[3] |=> wb.write_top
      && wb.raised_overflow && wb.round_up == $past(req.rounded_up)
      && wb.top_value[78:64] == 15'($past(rexp) + EXP_BIAS - REBIAS))
      else $error("unmasked overflow rebias wrong");
   a_unf_rebias: assert property (s_reg_req ##0 rexp < EMIN_EXT
      && rexp >= EMIN_EXT - REBIAS && !control_word[4] |=> wb.write_top
      && wb.raised_underflow && wb.round_up == $past(req.rounded_up)
      && wb.top_value[78:64] == 15'($past(rexp) + EXP_BIAS + REBIAS))
      else $error("unmasked underflow rebias wrong");
endmodule

bind fze_exceptions fze_exceptions_asserts chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .prdata(prdata), .pslverr(pslverr), .req(req), .wait_check(wait_check),
   .wb(wb), .handler_req(handler_req), .control_word(control_word),
   .status_word(status_word)
);

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
   import fze_pkg::*;
   logic        pclk;
   logic        presetn;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] paddr;
   logic [31:0] pwdata;
   logic        pready;
   logic [31:0] prdata;
   logic        pslverr;
   fze_req_s    req;
   logic        wait_check;
   fze_wb_s     wb;
   logic        handler_req;
   logic [15:0] control_word;
   logic [15:0] status_word;
   int          num_errors;
   int          n_checks;
   logic [31:0] rd;
   logic        er;
   fze_req_s    r;
   int          e;
   logic        s;
   fze_op_e     dops[5] = '{FZE_OP_DIVIDE, FZE_OP_DIVIDE_POP,
      FZE_OP_REVERSE_DIVIDE, FZE_OP_INTEGER_DIVIDE,
      FZE_OP_INTEGER_REVERSE_DIVIDE};
   fze_op_e     sops[4] = '{FZE_OP_FLOAT_STORE, FZE_OP_FLOAT_STORE_POP,
      FZE_OP_INTEGER_STORE, FZE_OP_DECIMAL_STORE};

   fze_exceptions dut_u (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .prdata(prdata), .pslverr(pslverr), .req(req),
      .wait_check(wait_check), .wb(wb), .handler_req(handler_req),
      .control_word(control_word), .status_word(status_word)
   );

   always #50 pclk = ~pclk;

   task automatic tally_and_finish;
      if (num_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic chk(string nm, logic [79:0] ex, logic [79:0] got);
      n_checks++;
      if (got !== ex) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, ex, got);
      end
   endtask

   // Waits on pready rather than assuming the single wait-free cycle
   task automatic apb(logic wr, logic [31:0] a, logic [31:0] d);
      int n;
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) num_errors++;
      rd = prdata;
      er = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task automatic go(fze_req_s q);
      @(posedge pclk);
      req <= q;
      @(posedge pclk);
      req <= '0;
      #1;
   endtask

   function automatic fze_req_s mk(fze_op_e op, logic dm, fze_fmt_e f,
                                   int ex, logic sg, logic ru);
      fze_req_s q;
      q = '0;
      {q.valid, q.a_finite, q.b_finite, q.res_number} = 4'hF;
      q.uses_precision = 1'b1;
      q.op = op;
      q.dest_mem = dm;
      q.fmt = f;
      q.res_sign = sg;
      q.res_exp = 18'(ex);
      q.res_sig = 64'h8000_0000_0000_0000;
      q.rounded_up = ru;
      return q;
   endfunction

   function automatic logic [14:0] ovf_exp(logic sg, fze_rc_e rc);
      if (rc == FZE_RC_NEAREST || (rc == FZE_RC_DOWN && sg) ||
          (rc == FZE_RC_UP && !sg)) return EXP_ALL_ONES;
      return 15'(EMAX_EXT + EXP_BIAS);
   endfunction

   function automatic logic [14:0] rebias(int ex);
      return 15'(ex > 0 ? ex - REBIAS + EXP_BIAS : ex + REBIAS + EXP_BIAS);
   endfunction

   initial begin
      #(1_000_000);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      {pclk, presetn, psel, penable, pwrite, wait_check} = 6'b0;
      {paddr, pwdata} = 64'h0;
      req = '0;
      num_errors = 0;
      n_checks = 0;
      e = $urandom(74);
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, ADDR_CONTROL, 32'h0);
      chk("ctrl_reset", 80'(CONTROL_RESET), 80'(rd));
      apb(1'b0, 32'h0000_0040, 32'h0);
      chk("unmapped", 80'h1_0000_0000, {er, rd});
      foreach (dops[i]) begin
         r = mk(dops[i], 1'b0, FZE_FMT_EXTENDED, 0, 1'b0, 1'b0);
         {r.a_zero, r.res_number} = 2'b10;
         if (dops[i] inside {FZE_OP_REVERSE_DIVIDE,
                             FZE_OP_INTEGER_REVERSE_DIVIDE}) begin
            {r.a_zero, r.b_zero} = 2'b01;
         end
         {r.a_sign, r.b_sign} = 2'($urandom);
         go(r);
         chk("div_inf", {1'b1, r.a_sign ^ r.b_sign, EXP_ALL_ONES},
             {wb.write_top, wb.top_value[79:64]});
      end
      s = 1'($urandom);
      r = mk(FZE_OP_LOG_PRODUCT, 1'b0, FZE_FMT_EXTENDED, 0, 1'b0, 1'b0);
      {r.a_zero, r.res_number, r.b_sign} = {2'b10, s};
      go(r);
      chk("log_inf", {1'b1, ~s, EXP_ALL_ONES},
          {wb.write_top, wb.top_value[79:64]});
      r = mk(FZE_OP_EXPONENT_EXTRACT, 1'b0, FZE_FMT_EXTENDED, 0, s, 1'b0);
      {r.a_zero, r.res_number, r.a_sign} = {2'b10, s};
      go(r);
      chk("ext_top", {s, 79'h0}, wb.top_value);
      chk("ext_second", {3'b111, EXP_ALL_ONES}, {wb.write_top,
          wb.write_second, wb.second_value[79:64]});
      apb(1'b0, ADDR_STATUS, 32'h0);
      chk("status_zd", 80'h4, 80'(rd));
      for (int m = 0; m < 4; m++) begin
         apb(1'b1, ADDR_CONTROL, 32'(CONTROL_RESET) | 32'(m << BIT_RC_LO));
         s = 1'($urandom);
         go(mk(FZE_OP_OTHER, 1'b0, FZE_FMT_EXTENDED,
            EMAX_EXT + 1 + $urandom_range(99), s, 1'b0));
         chk("ovf_masked", {1'b1, s, ovf_exp(s, fze_rc_e'(m))},
             {wb.write_top, wb.top_value[79:64]});
      end
      go(mk(FZE_OP_OTHER, 1'b0, FZE_FMT_EXTENDED, EMIN_EXT - 3, s, 1'b0));
      chk("unf_masked", {s, 15'h0, 64'h8000_0000_0000_0000 >> 3},
          wb.top_value);
      apb(1'b1, ADDR_CONTROL, 32'h0000_0300);
      for (int i = 0; i < 8; i++) begin
         s = 1'($urandom);
         e = (i < 2) ? REBIAS : $urandom_range(REBIAS - 1) + 1;
         e = i[0] ? EMIN_EXT - e : EMAX_EXT + e;
         go(mk(FZE_OP_OTHER, 1'b0, FZE_FMT_EXTENDED, e, s, i[1]));
         chk("rebias", {1'b1, s, rebias(e)},
             {wb.write_top, wb.top_value[79:64]});
         chk("round_up", {i[1], i[1]},
             {wb.round_up, status_word[BIT_ROUND_UP]});
      end
      chk("flags_all", 80'h029C, 80'(status_word));
      chk("no_handler", 80'h0, 80'(handler_req));
      @(posedge pclk);
      wait_check <= 1'b1;
      @(posedge pclk);
      wait_check <= 1'b0;
      #1 chk("handler", 80'h1, 80'(handler_req));
      apb(1'b1, ADDR_STATUS, 32'h0000_029C);
      r = mk(FZE_OP_DIVIDE, 1'b0, FZE_FMT_EXTENDED, 0, 1'b0, 1'b0);
      {r.a_zero, r.res_number} = 2'b10;
      go(r);
      chk("div_unmasked", 80'h0_0084, {wb.write_top, status_word});
      foreach (sops[i]) begin
         go(mk(sops[i], 1'b1, FZE_FMT_SINGLE,
            i[0] ? EMIN_SINGLE - 1 : EMAX_SINGLE + 1, 1'b0, 1'b1));
         chk("store_raise", (i < 2) ? {i[0], !i[0]} : 2'b00,
             {wb.raised_underflow, wb.raised_overflow});
         if (i < 2) chk("store_nowr", 80'h0,
             {wb.write_top, wb.round_up});
      end
      for (int i = 0; i < 2; i++) begin
         s = 1'($urandom);
         go(mk(FZE_OP_SCALE, 1'b0, FZE_FMT_EXTENDED,
            i ? EMIN_EXT - REBIAS - 1 : EMAX_EXT + REBIAS + 1, s, 1'b0));
         chk("scale", {1'b1, s, i ? 15'h0 : EXP_ALL_ONES},
             {wb.write_top, wb.top_value[79:64]});
      end
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      #1 chk("rst_again", {CONTROL_RESET, STATUS_RESET},
             {control_word, status_word});
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      tally_and_finish();
   end
endmodule
